// file: hdl/ldc_top.sv
// led string dimming control: range select and pwm modulator gating both sinks
// What this block does
// - range bit one selects high range resistor
// - range bit zero, default, selects low range
// - pwm gates both sinks together, 200 Hz
// - duty 1 to 100 percent, default 30
// - writing 63h gives constant full duty
// - enable and settings from control registers
// how it works: a divider makes a one-cycle step pulse every STEP_CYCLES clocks,
// and a phase counter walks 0 to 99 on those pulses, so one pwm period is 100 steps.
// both sinks share one flop, so they can never switch apart by a cycle.
// the sink is on while the phase is not above the duty code, which gives code+1
// steps of 100; codes from 63h upward hold the sinks on for the whole period.
// limitation: a new duty code takes effect at once, mid-period, so the period in
// which software writes may show one odd pulse width.
// while the converter is disabled the divider and phase are parked at zero, so the
// first period after enable always starts with the sinks on.
`default_nettype none
module ldc_top #(
  parameter int STEP_CYCLES = ldc_pkg::LDC_STEP_CYCLES
) (
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic WRITE_ENABLE,
  input wire logic [7:0] ADDRESS,
  input wire logic [7:0] WRITE_DATA,
  output logic [7:0] READ_DATA,
  output logic HIGH_RANGE_SELECT,
  output logic LOW_RANGE_SELECT,
  output logic FIRST_STRING_SINK,
  output logic SECOND_STRING_SINK,
  output logic CONVERTER_ENABLE
);
  import ldc_pkg::*;
  // refuse step counts the divider cannot serve: the step counter is sixteen bits wide,
  // and a count of zero would wrap the compare value to 65535, giving a 65536-cycle step
  if (STEP_CYCLES < 1 || STEP_CYCLES > 65535) begin : g_bad_step
    $error("STEP_CYCLES out of range");
  end
  // register store, read data registered one cycle behind the address
  logic [7:0] dimming; // range bit and duty code
  logic [7:0] ctrl_first; // bit 0 enables the converter
  logic [7:0] ctrl_second; // stored for software, no effect here
  logic [7:0] read_data; // registered read data
  ldc_regfile u_regs (
    .clock(CLOCK),
    .arst_n(ARST_N),
    .write_enable(WRITE_ENABLE),
    .address(ADDRESS),
    .write_data(WRITE_DATA),
    .read_data(read_data),
    .dimming(dimming),
    .ctrl_first(ctrl_first),
    .ctrl_second(ctrl_second)
  );
  assign READ_DATA = read_data;
  logic enable; // converter enable from control
  logic [6:0] duty_code; // saturated duty code
  logic [15:0] step_count; // divider for one percent step
  logic step_tick; // one percent step enable
  logic [6:0] phase; // position within pwm period
  ldc_state_type state; // modulator idle or running
  logic [15:0] next_step_count; // next divider count
  logic next_step_tick; // next step pulse
  logic [6:0] next_phase; // next phase
  ldc_state_type next_state; // next modulator state
  logic next_sink; // next gate for both sinks
  logic sink; // gate shared by both sinks
  logic next_high_range; // next high range select
  logic high_range; // high range select flop
  logic next_low_range; // next low range select
  logic low_range; // low range select flop
  logic next_enable_out; // next converter enable output
  logic enable_out; // converter enable flop
  // control decode and duty saturation
  always_comb begin
    enable = ctrl_first[LDC_ENABLE_BIT];
    // codes above 63h would ask for more than 100 percent, so clamp them
    if (dimming[LDC_DUTY_MSB:0] > LDC_DUTY_MAX_CODE) begin
      duty_code = LDC_DUTY_MAX_CODE;
    end else begin
      // codes up to 63h pass through unchanged
      duty_code = dimming[LDC_DUTY_MSB:0];
    end
  end
  // modulator next values
  always_comb begin
    next_step_count = step_count;
    next_step_tick = 1'b0;
    next_phase = phase;
    next_state = state;
    next_sink = 1'b0;
    case (state)
      LDC_IDLE: begin
        // parked: divider and phase held at zero so enable starts a clean period
        next_step_count = 16'h0000;
        next_phase = 7'h00;
        if (enable) begin
          next_state = LDC_RUN;
        end
      end
      LDC_RUN: begin
        // running: stop at once when software clears the enable
        if (!enable) begin
          next_state = LDC_IDLE;
        end else begin
          // step divider, 100 steps make one 200 Hz period
          if (step_count == 16'(STEP_CYCLES - 1)) begin
            next_step_count = 16'h0000;
            next_step_tick = 1'b1;
          end else begin
            next_step_count = step_count + 16'h0001;
          end
          // phase advances once per step and wraps after the hundredth
          if (step_tick) begin
            next_phase = (phase == LDC_STEPS - 7'h01) ? 7'h00 : phase + 7'h01;
          end
          // on while phase <= code: code+1 steps of 100; 63h is always on
          next_sink = (next_phase <= duty_code);
        end
      end
      // an unused code falls back to idle
      default: next_state = LDC_IDLE;
    endcase
  end
  // modulator registers
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      step_count <= 16'h0000;
      step_tick <= 1'b0;
      phase <= 7'h00;
      state <= LDC_IDLE;
      sink <= 1'b0;
    end else begin
      step_count <= next_step_count;
      step_tick <= next_step_tick;
      phase <= next_phase;
      state <= next_state;
      sink <= next_sink;
    end
  end
  // range and enable next values: the range pair is decoded from one bit, so the two
  // selects can never be on together, and the enable is delayed one cycle like the rest
  always_comb begin
    next_high_range = dimming[LDC_RANGE_BIT];
    next_low_range = !dimming[LDC_RANGE_BIT];
    next_enable_out = enable;
  end
  // range and enable registers; low range is the reset default
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      high_range <= 1'b0;
      low_range <= 1'b1;
      enable_out <= 1'b0;
    end else begin
      high_range <= next_high_range;
      low_range <= next_low_range;
      enable_out <= next_enable_out;
    end
  end
  // every output comes straight from a flop; both sinks share one so they switch together
  assign FIRST_STRING_SINK = sink;
  assign SECOND_STRING_SINK = sink;
  assign HIGH_RANGE_SELECT = high_range;
  assign LOW_RANGE_SELECT = low_range;
  assign CONVERTER_ENABLE = enable_out;
  // range selects are exclusive, one of the two resistors is always chosen
  a_range_exclusive: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    HIGH_RANGE_SELECT != LOW_RANGE_SELECT)
    else $error("range selects not exclusive");
  // high range select trails the range bit by one cycle
  a_range_follow: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    ##1 HIGH_RANGE_SELECT == $past(dimming[LDC_RANGE_BIT]))
    else $error("range not following bit");
  // the two sink gates never differ
  a_sinks_together: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    FIRST_STRING_SINK == SECOND_STRING_SINK)
    else $error("sinks differ");
  // with the top code held while running, the sinks never switch off
  a_full_duty: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (state == LDC_RUN && enable && duty_code == LDC_DUTY_MAX_CODE) [*2] |-> sink)
    else $error("full duty not constant");
  // a parked modulator keeps the sinks off
  a_off_disabled: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (!enable && state == LDC_IDLE) |=> !sink)
    else $error("sink on while disabled");
  // the clamped code never exceeds the full duty code
  a_duty_saturate: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    duty_code <= LDC_DUTY_MAX_CODE)
    else $error("duty code above limit");
  // in steady running the gate is on exactly while phase is not above the code
  a_phase_duty: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (state == LDC_RUN && $past(state) == LDC_RUN && enable && $stable(duty_code)) |->
    (sink == (phase <= duty_code)))
    else $error("sink disagrees with phase");
  // the phase stays inside one period of 100 steps
  a_phase_wrap: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    phase < LDC_STEPS)
    else $error("phase out of range");
  // converter enable output trails the control bit by one cycle
  a_enable_follow: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    ##1 CONVERTER_ENABLE == $past(ctrl_first[LDC_ENABLE_BIT]))
    else $error("enable not following control");
  // the phase only moves on a step pulse, which fixes the period length
  a_phase_step: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (state == LDC_RUN && enable && !step_tick) |=> $stable(phase))
    else $error("phase moved without a step");
  // cover: converter switched on
  c_enable: cover property (@(posedge CLOCK) disable iff (!ARST_N) $rose(CONVERTER_ENABLE));
  // cover: a sink pulse ends inside a period
  c_sink_off: cover property (@(posedge CLOCK) disable iff (!ARST_N) $fell(FIRST_STRING_SINK));
  // cover: high range chosen
  c_high_range: cover property (@(posedge CLOCK) disable iff (!ARST_N) HIGH_RANGE_SELECT);
  // cover: the top code reached while running
  c_full_duty: cover property (@(posedge CLOCK) disable iff (!ARST_N)
    state == LDC_RUN && duty_code == LDC_DUTY_MAX_CODE);
  // cover: the phase wraps at the end of a period
  c_phase_wrap: cover property (@(posedge CLOCK) disable iff (!ARST_N)
    step_tick && phase == LDC_STEPS - 7'h01);
endmodule
`default_nettype wire

// file: hdl/ldc_pkg.sv
// package: register map, field layout, reset values and timing counts for the led dimming control
`default_nettype none
package ldc_pkg;
  // register offsets
  localparam logic [7:0] LDC_OFFSET_DIMMING = 8'h19;
  localparam logic [7:0] LDC_OFFSET_CTRL_FIRST = 8'h1a;
  localparam logic [7:0] LDC_OFFSET_CTRL_SECOND = 8'h1b;
  // dimming register fields
  localparam int LDC_RANGE_BIT = 7;
  localparam int LDC_DUTY_MSB = 6;
  // control register fields
  localparam int LDC_ENABLE_BIT = 0;
  // reset values: low range, duty code 29 means 30 percent
  localparam logic [7:0] LDC_DIMMING_RESET = 8'h1d;
  localparam logic [7:0] LDC_CTRL_FIRST_RESET = 8'h00;
  localparam logic [7:0] LDC_CTRL_SECOND_RESET = 8'h00;
  // duty code limits
  localparam logic [6:0] LDC_DUTY_MAX_CODE = 7'h63;
  localparam logic [6:0] LDC_STEPS = 7'h64;
  // timing
  localparam int LDC_CLOCK_HZ = 10000000;
  localparam int LDC_PWM_HZ = 200;
  localparam int LDC_STEP_CYCLES = LDC_CLOCK_HZ / (LDC_PWM_HZ * 100);
  // state of the modulator
  typedef enum logic [0:0] {
    LDC_IDLE = 1'b0,
    LDC_RUN = 1'b1
  } ldc_state_type;
endpackage
`default_nettype wire

// file: hdl/ldc_regfile.sv
// small register store: three byte registers with registered read data
`default_nettype none
module ldc_regfile (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic write_enable,
  input wire logic [7:0] address,
  input wire logic [7:0] write_data,
  output logic [7:0] read_data,
  output logic [7:0] dimming,
  output logic [7:0] ctrl_first,
  output logic [7:0] ctrl_second
);
  import ldc_pkg::*;
  logic [7:0] next_dimming;
  logic [7:0] next_ctrl_first;
  logic [7:0] next_ctrl_second;
  logic [7:0] next_read_data;
  // write decode and read mux
  always_comb begin
    next_dimming = dimming;
    next_ctrl_first = ctrl_first;
    next_ctrl_second = ctrl_second;
    if (write_enable && address == LDC_OFFSET_DIMMING) begin
      next_dimming = write_data;
    end
    if (write_enable && address == LDC_OFFSET_CTRL_FIRST) begin
      next_ctrl_first = write_data;
    end
    if (write_enable && address == LDC_OFFSET_CTRL_SECOND) begin
      next_ctrl_second = write_data;
    end
    case (address)
      LDC_OFFSET_DIMMING: next_read_data = dimming;
      LDC_OFFSET_CTRL_FIRST: next_read_data = ctrl_first;
      LDC_OFFSET_CTRL_SECOND: next_read_data = ctrl_second;
      default: next_read_data = 8'h00;
    endcase
  end
  // register stage
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      dimming <= LDC_DIMMING_RESET;
      ctrl_first <= LDC_CTRL_FIRST_RESET;
      ctrl_second <= LDC_CTRL_SECOND_RESET;
      read_data <= 8'h00;
    end else begin
      dimming <= next_dimming;
      ctrl_first <= next_ctrl_first;
      ctrl_second <= next_ctrl_second;
      read_data <= next_read_data;
    end
  end
endmodule
`default_nettype wire

// file: tb/test_ldc_top.sv
// self-checking bench for the led dimming control: registers, range select and pwm duty
`default_nettype none
module test_ldc_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ldc_pkg::*;
  localparam int STEP = 2; // short step so one period is 200 cycles
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic write_enable = 1'b0;
  logic [7:0] address = 8'h00;
  logic [7:0] write_data = 8'h00;
  logic [7:0] read_data;
  logic high_sel, low_sel, sink_a, sink_b, conv_en;
  int bad_count = 0;
  int total_checks = 0;
  // clock generator, 100 ns period
  always #50 clock = ~clock;
  ldc_top #(.STEP_CYCLES(STEP)) DUT (
    .CLOCK(clock), .ARST_N(arst_n), .WRITE_ENABLE(write_enable), .ADDRESS(address),
    .WRITE_DATA(write_data), .READ_DATA(read_data), .HIGH_RANGE_SELECT(high_sel),
    .LOW_RANGE_SELECT(low_sel), .FIRST_STRING_SINK(sink_a), .SECOND_STRING_SINK(sink_b),
    .CONVERTER_ENABLE(conv_en)
  );
  // compare one value with its expectation
  task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
    total_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("wrong value at %0t: %s seen %h want %h", $time, what, seen, want);
    end
  endtask
  // one write cycle, driven on falling edges
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    write_enable = 1'b1;
    address = a;
    write_data = d;
    @(negedge clock);
    write_enable = 1'b0;
  endtask
  // registered read, one cycle latency
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    address = a;
    @(negedge clock);
    d = read_data;
  endtask
  // reset values and unmapped address
  task automatic test_reset();
    logic [7:0] d;
    reg_read(LDC_OFFSET_DIMMING, d);
    check(d, 8'h1d, "dimming reset");
    check({7'h00, low_sel}, 8'h01, "low range at reset");
    check({7'h00, high_sel}, 8'h00, "high range at reset");
    check({7'h00, conv_en}, 8'h00, "enable at reset");
    reg_write(8'h40, 8'h5a);
    reg_read(8'h40, d);
    check(d, 8'h00, "unmapped read");
    $display("test reset done");
  endtask
  // range bit toggles which resistor input is selected
  task automatic test_range();
    reg_write(LDC_OFFSET_DIMMING, 8'h9d);
    repeat (2) @(negedge clock);
    check({6'h00, high_sel, low_sel}, 8'h02, "high range");
    reg_write(LDC_OFFSET_DIMMING, 8'h1d);
    repeat (2) @(negedge clock);
    check({6'h00, high_sel, low_sel}, 8'h01, "low range");
    $display("test range done");
  endtask
  // count sink on-cycles over one full period for a given code
  task automatic measure(input logic [7:0] code, input int want_on);
    int on_count;
    on_count = 0;
    if (code != 8'hff) reg_write(LDC_OFFSET_DIMMING, code);
    repeat (100 * STEP + 4) @(negedge clock);
    for (int i = 0; i < 100 * STEP; i++) begin
      @(negedge clock);
      check({7'h00, sink_b}, {7'h00, sink_a}, "sinks together");
      if (sink_a === 1'b1) on_count++;
    end
    check(8'(on_count), 8'(want_on), "on cycles per period");
  endtask
  // pwm duty across codes, enable and disable
  task automatic test_pwm();
    logic [7:0] d;
    reg_write(LDC_OFFSET_CTRL_FIRST, 8'h01);
    repeat (2) @(negedge clock);
    check({7'h00, conv_en}, 8'h01, "converter enable");
    measure(8'hff, 30 * STEP);
    measure(8'h00, 1 * STEP);
    measure(8'h63, 100 * STEP);
    measure(8'h7f, 100 * STEP);
    measure(8'h31, 50 * STEP);
    reg_read(LDC_OFFSET_DIMMING, d);
    check(d, 8'h31, "dimming readback");
    reg_write(LDC_OFFSET_CTRL_FIRST, 8'h00);
    measure(8'h63, 0);
    check({7'h00, conv_en}, 8'h00, "converter disabled");
    reg_write(LDC_OFFSET_CTRL_SECOND, 8'ha5);
    reg_read(LDC_OFFSET_CTRL_SECOND, d);
    check(d, 8'ha5, "second control readback");
    $display("test pwm done");
  endtask
  // reset in mid-run brings back the defaults
  task automatic test_rearm();
    logic [7:0] d;
    reg_write(LDC_OFFSET_CTRL_FIRST, 8'h01);
    reg_write(LDC_OFFSET_DIMMING, 8'h80);
    repeat (4) @(negedge clock);
    arst_n = 1'b0;
    @(negedge clock);
    check({6'h00, high_sel, low_sel}, 8'h01, "range during reset");
    check({6'h00, conv_en, sink_a}, 8'h00, "outputs during reset");
    check(read_data, 8'h00, "read data during reset");
    arst_n = 1'b1;
    reg_read(LDC_OFFSET_DIMMING, d);
    check(d, 8'h1d, "dimming after reset");
    reg_read(LDC_OFFSET_CTRL_FIRST, d);
    check(d, 8'h00, "control after reset");
    $display("test rearm done");
  endtask
  // verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (3) @(negedge clock);
    arst_n = 1'b1;
    test_reset();
    test_range();
    test_pwm();
    test_rearm();
    stop_test();
  end
endmodule
`default_nettype wire
